// >>> log_pkg.sv
package log_pkg;

    // Register numbers on the serial register port
    localparam logic [15:0] REG_LOG_WRITE_PTR    = 16'h01e9;
    localparam logic [15:0] REG_LOG_READ_PTR     = 16'h01eb;
    localparam logic [15:0] REG_SAMPLE_LIMIT     = 16'h116e;
    localparam logic [15:0] REG_MODULE_TYPE      = 16'h20ea;
    localparam logic [15:0] REG_STATUS_FLAGS     = 16'h20eb;
    localparam logic [15:0] REG_FIRMWARE_VERSION = 16'h20ec;
    localparam logic [15:0] REG_CARD_CAPACITY    = 16'h20f0;
    localparam logic [15:0] REG_SINGLE_LOG_READ  = 16'h40a9;
    localparam logic [15:0] REG_MULTI_LOG_READ   = 16'h40ab;

    // Status flag bit positions
    localparam int ST_TIME_CLOCK_FITTED = 0;
    localparam int ST_OSC_FAULT         = 1;
    localparam int ST_RANGE_FAULT       = 2;
    localparam int ST_READ_PTR_ERR      = 3;
    localparam int ST_WRITE_PTR_ERR     = 4;
    localparam int ST_BAD_CARD          = 5;
    localparam int ST_UNFORMATTED       = 6;
    localparam int ST_CARD_READY        = 7;

    // Capacity code fields
    localparam int CAP_EXP_MSB  = 7;
    localparam int CAP_EXP_LSB  = 4;
    localparam int CAP_MANT_MSB = 3;
    localparam int CAP_MANT_LSB = 0;

    // Reset values and the unit increment
    localparam logic [15:0] PTR_RST   = 16'h0000;
    localparam logic [15:0] LIMIT_RST = 16'h0000;
    localparam logic [15:0] ONE_16    = 16'h0001;
    localparam logic [7:0]  BYTE_RST  = 8'h00;

    typedef enum logic [1:0] {
        MODE_ASCII  = 2'h0,
        MODE_MODBUS = 2'h1,
        MODE_OTHER  = 2'h2,
        MODE_MACRO  = 2'h3
    } access_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_STREAM = 2'b10
    } read_state_t;

endpackage : log_pkg

// >>> card_info_if.sv
`timescale 1ns/1ps
interface card_info_if;
    logic [7:0] module_type;
    logic [7:0] status_flags;
    logic [7:0] fw_version;
    logic [7:0] capacity_code;

    modport src (
        output module_type,
        output status_flags,
        output fw_version,
        output capacity_code
    );
    modport dst (
        input  module_type,
        input  status_flags,
        input  fw_version,
        input  capacity_code
    );
endinterface : card_info_if

// >>> card_info_sync.sv
`timescale 1ns/1ps
module card_info_sync
    import log_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] module_type_i,
    input  wire logic [7:0] status_flags_i,
    input  wire logic [7:0] fw_version_i,
    input  wire logic [7:0] capacity_code_i,
    card_info_if.src        info
);

    typedef struct packed {
        logic [31:0] meta;
        logic [31:0] held;
    } sync_t;

    sync_t st_r;
    sync_t st_nxt;

    // Two flops before the main logic sees the logger module bytes
    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = {module_type_i, status_flags_i, fw_version_i, capacity_code_i};
        st_nxt.held = st_r.meta;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign info.module_type   = st_r.held[31:24];
    assign info.status_flags  = st_r.held[23:16];
    assign info.fw_version    = st_r.held[15:8];
    assign info.capacity_code = st_r.held[7:0];

    a_status_two_flops: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        $past(nrst_i, 2) |-> info.status_flags == $past(status_flags_i, 2))
        else $error("status flags not two cycles behind the logger");

endmodule : card_info_sync

// >>> log_readout.sv
`timescale 1ns/1ps
module log_readout
    import log_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic         req_valid_i,
    input  wire logic         req_write_i,
    input  wire access_mode_t req_mode_i,
    input  wire logic [15:0]  req_addr_i,
    input  wire logic [15:0]  req_wdata_i,
    output logic              busy_o,
    output logic              rsp_valid_o,
    output logic [15:0]       rsp_data_o,
    output logic              rsp_err_o,
    output logic              rsp_nodata_o,
    output logic              rsp_done_o,
    output logic              smp_valid_o,
    output logic [15:0]       smp_index_o,
    input  wire logic         smp_ready_i,
    input  wire logic         log_sample_i,
    input  wire logic [7:0]   card_module_type_i,
    input  wire logic [7:0]   card_status_i,
    input  wire logic [7:0]   card_fw_version_i,
    input  wire logic [7:0]   card_capacity_i
);

    typedef struct packed {
        read_state_t state;
        logic [15:0] rd;
        logic [15:0] wr;
        logic [15:0] limit;
        logic [15:0] cnt;
        logic        busy;
        logic        rsp_valid;
        logic [15:0] rsp_data;
        logic        rsp_err;
        logic        rsp_nodata;
        logic        rsp_done;
        logic        smp_valid;
        logic [15:0] smp_index;
    } readout_t;

    readout_t st_r;
    readout_t st_nxt;

    card_info_if info ();

    card_info_sync u_card_info (
        .clk_i           (clk_i),
        .nrst_i          (nrst_i),
        .module_type_i   (card_module_type_i),
        .status_flags_i  (card_status_i),
        .fw_version_i    (card_fw_version_i),
        .capacity_code_i (card_capacity_i),
        .info            (info.src)
    );

    logic take;
    logic ptr_equal;

    assign take      = req_valid_i && (st_r.state == ST_IDLE);
    assign ptr_equal = (st_r.rd == st_r.wr);

    always_comb begin
        st_nxt            = st_r;
        st_nxt.rsp_valid  = 1'b0;
        st_nxt.rsp_err    = 1'b0;
        st_nxt.rsp_nodata = 1'b0;
        st_nxt.rsp_done   = 1'b0;
        // New samples logged by the device advance the write pointer, unless a write to it loads it in the same cycle
        if (log_sample_i) begin
            st_nxt.wr = st_r.wr + ONE_16;
        end
        case (st_r.state)
            ST_IDLE: begin
                if (take) begin
                    st_nxt.rsp_valid = 1'b1;
                    st_nxt.rsp_data  = PTR_RST;
                    if (req_write_i) begin
                        // Pointer writes select a range or clear the log
                        case (req_addr_i)
                            REG_LOG_WRITE_PTR: begin
                                st_nxt.wr = req_wdata_i;
                            end
                            REG_LOG_READ_PTR: begin
                                st_nxt.rd = req_wdata_i;
                            end
                            REG_SAMPLE_LIMIT: begin
                                st_nxt.limit = req_wdata_i;
                            end
                            default: begin
                                st_nxt.rsp_err = 1'b1;
                            end
                        endcase
                    end else begin
                        case (req_addr_i)
                            REG_LOG_WRITE_PTR: begin
                                st_nxt.rsp_data = st_r.wr;
                            end
                            REG_LOG_READ_PTR: begin
                                st_nxt.rsp_data = st_r.rd;
                            end
                            REG_SAMPLE_LIMIT: begin
                                st_nxt.rsp_data = st_r.limit;
                            end
                            REG_MODULE_TYPE: begin
                                st_nxt.rsp_data = {BYTE_RST, info.module_type};
                            end
                            REG_STATUS_FLAGS: begin
                                // Flags pass through
                                st_nxt.rsp_data = {BYTE_RST, info.status_flags};
                            end
                            REG_FIRMWARE_VERSION: begin
                                st_nxt.rsp_data = {BYTE_RST, info.fw_version};
                            end
                            REG_CARD_CAPACITY: begin
                                st_nxt.rsp_data = {BYTE_RST, info.capacity_code};
                            end
                            REG_SINGLE_LOG_READ: begin
                                if (ptr_equal) begin
                                    st_nxt.rsp_nodata = 1'b1;
                                end else begin
                                    st_nxt.rd       = st_r.rd + ONE_16;
                                    st_nxt.rsp_data = st_r.rd + ONE_16;
                                end
                            end
                            REG_MULTI_LOG_READ: begin
                                if (req_mode_i != MODE_ASCII) begin
                                    st_nxt.rsp_err = 1'b1;
                                end else if (ptr_equal) begin
                                    st_nxt.rsp_done = 1'b1;
                                end else begin
                                    st_nxt.rsp_valid = 1'b0;
                                    st_nxt.state     = ST_STREAM;
                                    st_nxt.cnt       = PTR_RST;
                                    st_nxt.smp_valid = 1'b1;
                                    st_nxt.smp_index = st_r.rd;
                                end
                            end
                            default: begin
                                st_nxt.rsp_err = 1'b1;
                            end
                        endcase
                    end
                end
            end
            ST_STREAM: begin
                if (smp_ready_i) begin
                    st_nxt.rd  = st_r.rd + ONE_16;
                    st_nxt.cnt = st_r.cnt + ONE_16;
                    // Stop on pointer match or on the sample limit
                    if ((st_nxt.rd == st_nxt.wr) ||
                        ((st_r.limit != LIMIT_RST) && (st_nxt.cnt == st_r.limit))) begin
                        st_nxt.state     = ST_IDLE;
                        st_nxt.smp_valid = 1'b0;
                        st_nxt.rsp_valid = 1'b1;
                        st_nxt.rsp_done  = 1'b1;
                        st_nxt.rsp_data  = st_nxt.cnt;
                    end else begin
                        st_nxt.smp_index = st_nxt.rd;
                    end
                end
            end
            default: begin
                st_nxt.state     = ST_IDLE;
                st_nxt.smp_valid = 1'b0;
            end
        endcase
        st_nxt.busy = (st_nxt.state == ST_STREAM);
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r            <= '0;
            st_r.state      <= ST_IDLE;
            st_r.rd         <= PTR_RST;
            st_r.wr         <= PTR_RST;
            st_r.limit      <= LIMIT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy_o       = st_r.busy;
    assign rsp_valid_o  = st_r.rsp_valid;
    assign rsp_data_o   = st_r.rsp_data;
    assign rsp_err_o    = st_r.rsp_err;
    assign rsp_nodata_o = st_r.rsp_nodata;
    assign rsp_done_o   = st_r.rsp_done;
    assign smp_valid_o  = st_r.smp_valid;
    assign smp_index_o  = st_r.smp_index;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    logic take_multi;
    logic take_single;

    assign take_multi  = take && !req_write_i && (req_addr_i == REG_MULTI_LOG_READ);
    assign take_single = take && !req_write_i && (req_addr_i == REG_SINGLE_LOG_READ);

    a_stream_start_index: assert property (
        take_multi && (req_mode_i == MODE_ASCII) && !ptr_equal
        |=> smp_valid_o && (smp_index_o == $past(st_r.rd)) && busy_o)
        else $error("multi read did not start at the read pointer");

    a_limit_not_exceeded: assert property (
        (st_r.state == ST_STREAM) && (st_r.limit != LIMIT_RST)
        |-> st_r.cnt < st_r.limit)
        else $error("stream ran past the sample limit");

    a_pointer_advances: assert property (
        smp_valid_o && smp_ready_i |=> st_r.rd == $past(st_r.rd) + ONE_16)
        else $error("read pointer did not advance on an emitted sample");

    a_end_pointers_meet: assert property (
        rsp_valid_o && rsp_done_o && (rsp_data_o != PTR_RST) &&
        ((st_r.limit == LIMIT_RST) || (rsp_data_o != st_r.limit))
        |-> st_r.rd == st_r.wr)
        else $error("stream ended with read and write pointers apart");

    a_ascii_only_multi: assert property (
        take_multi && (req_mode_i != MODE_ASCII)
        |=> rsp_valid_o && rsp_err_o && !smp_valid_o)
        else $error("multi read served outside ascii mode");

    a_single_no_data: assert property (
        take_single && ptr_equal
        |=> rsp_valid_o && rsp_nodata_o && $stable(st_r.rd))
        else $error("single read with equal pointers gave data");

    a_equal_no_stream: assert property (
        take_multi && (req_mode_i == MODE_ASCII) && ptr_equal
        |=> rsp_done_o && !smp_valid_o && $stable(st_r.rd)
        ##1 (!smp_valid_o || $past(take_multi)))
        else $error("multi read with equal pointers emitted samples");

    a_capacity_read: assert property (
        take && !req_write_i && (req_addr_i == REG_CARD_CAPACITY)
        |=> rsp_data_o == {BYTE_RST, $past(info.capacity_code)})
        else $error("capacity read returned the wrong byte");

    a_status_read: assert property (
        take && !req_write_i && (req_addr_i == REG_STATUS_FLAGS)
        |=> rsp_data_o == {BYTE_RST, $past(info.status_flags)})
        else $error("status read returned the wrong byte");

    a_stream_holds_valid: assert property (
        smp_valid_o && !smp_ready_i |=> smp_valid_o && $stable(smp_index_o))
        else $error("sample dropped without ready");

    a_busy_no_answer: assert property (
        busy_o |=> !rsp_err_o && !rsp_nodata_o)
        else $error("error or no-data answer during a stream");

    a_busy_keeps_limit: assert property (
        busy_o |=> $stable(st_r.limit))
        else $error("sample limit changed during a stream");

    a_stop_on_limit: assert property (
        (st_r.state == ST_STREAM) && smp_ready_i && (st_r.limit != LIMIT_RST) &&
        ((st_r.cnt + ONE_16) == st_r.limit)
        |=> !smp_valid_o && !busy_o && rsp_valid_o && rsp_done_o)
        else $error("stream did not stop at the sample limit");

    a_stop_on_meet: assert property (
        (st_r.state == ST_STREAM) && smp_ready_i && !log_sample_i &&
        ((st_r.rd + ONE_16) == st_r.wr)
        |=> !smp_valid_o && !busy_o && rsp_done_o && (st_r.rd == st_r.wr))
        else $error("stream did not stop when the pointers met");

    a_stream_next_index: assert property (
        smp_valid_o && smp_ready_i
        |=> !smp_valid_o || (smp_index_o == $past(smp_index_o) + ONE_16))
        else $error("stream skipped or repeated a sample");

    a_write_ptr_loaded: assert property (
        take && req_write_i && (req_addr_i == REG_LOG_WRITE_PTR)
        |=> (st_r.wr == $past(req_wdata_i)) && rsp_valid_o && !rsp_err_o)
        else $error("write pointer write did not land");

    a_read_ptr_loaded: assert property (
        take && req_write_i && (req_addr_i == REG_LOG_READ_PTR)
        |=> (st_r.rd == $past(req_wdata_i)) && rsp_valid_o && !rsp_err_o)
        else $error("read pointer write did not land");

    a_write_ptr_counts: assert property (
        log_sample_i && !(take && req_write_i && (req_addr_i == REG_LOG_WRITE_PTR))
        |=> st_r.wr == $past(st_r.wr) + ONE_16)
        else $error("logged sample did not advance the write pointer");

    a_single_advances: assert property (
        take_single && !ptr_equal
        |=> rsp_valid_o && !rsp_nodata_o && (st_r.rd == $past(st_r.rd) + ONE_16) &&
            (rsp_data_o == st_r.rd))
        else $error("single read did not step the read pointer");

    a_refused_keeps_ptrs: assert property (
        take_multi && (req_mode_i != MODE_ASCII) |=> $stable(st_r.rd) && !busy_o)
        else $error("refused multi read moved the read pointer");

    a_module_type_read: assert property (
        take && !req_write_i && (req_addr_i == REG_MODULE_TYPE)
        |=> rsp_data_o == {BYTE_RST, $past(info.module_type)})
        else $error("module type read returned the wrong byte");

    a_firmware_read: assert property (
        take && !req_write_i && (req_addr_i == REG_FIRMWARE_VERSION)
        |=> rsp_data_o == {BYTE_RST, $past(info.fw_version)})
        else $error("firmware version read returned the wrong byte");

    a_answer_one_cycle: assert property (
        rsp_valid_o && !take |=> !rsp_valid_o)
        else $error("answer pulse longer than one cycle");

    a_flags_need_valid: assert property (
        rsp_err_o || rsp_nodata_o || rsp_done_o |-> rsp_valid_o)
        else $error("answer flag without answer strobe");

    c_full_stream: cover property (
        take_multi && (req_mode_i == MODE_ASCII) ##[1:20] rsp_done_o);

    c_limit_stop: cover property (
        rsp_done_o && (st_r.limit != LIMIT_RST) && (rsp_data_o == st_r.limit));

    c_single_data: cover property (
        take_single && !ptr_equal);

    c_refused_mode: cover property (
        take_multi && (req_mode_i == MODE_MODBUS));

endmodule : log_readout

// >>> card_logger_model.sv
`timescale 1ns/1ps
module card_logger_model
    import log_pkg::*;
#(
    parameter logic [7:0] MODULE_TYPE = 8'h5a, // Arbitrary value
    parameter logic [7:0] FW_VERSION  = 8'h13,
    parameter logic [7:0] CAPACITY    = 8'h58
)(
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic [7:0]  status_i,
    input  wire logic [3:0]  log_burst_i,
    input  wire logic        log_go_i,
    input  wire logic        slow_i,
    input  wire logic        clr_i,
    input  wire logic        smp_valid_i,
    input  wire logic [15:0] smp_index_i,
    output logic             smp_ready_o,
    output logic             log_sample_o,
    output logic [7:0]       module_type_o,
    output logic [7:0]       status_o,
    output logic [7:0]       fw_version_o,
    output logic [7:0]       capacity_o,
    output logic [15:0]      acc_count_o,
    output logic [15:0]      first_index_o,
    output logic [15:0]      last_index_o,
    output logic             seq_err_o
);
    logic [3:0] pend_r;
    logic [1:0] phase_r;

    assign module_type_o = MODULE_TYPE;
    assign status_o      = status_i;
    assign fw_version_o  = FW_VERSION;
    assign capacity_o    = CAPACITY;
    assign log_sample_o  = (pend_r != 4'h0);
    // Slow sink accepts one sample in four cycles
    assign smp_ready_o   = slow_i ? (phase_r == 2'h0) : 1'b1;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_r        <= 4'h0;
            phase_r       <= 2'h0;
            acc_count_o   <= 16'h0000;
            first_index_o <= 16'h0000;
            last_index_o  <= 16'h0000;
            seq_err_o     <= 1'b0;
        end else begin
            phase_r <= phase_r + 2'h1;
            if (log_go_i) begin
                pend_r <= log_burst_i;
            end else if (pend_r != 4'h0) begin
                pend_r <= pend_r - 4'h1;
            end
            if (clr_i) begin
                acc_count_o <= 16'h0000;
                seq_err_o   <= 1'b0;
            end else if (smp_valid_i && smp_ready_o) begin
                if (acc_count_o == 16'h0000) begin
                    first_index_o <= smp_index_i;
                end else if (smp_index_i != last_index_o + 16'h0001) begin
                    seq_err_o <= 1'b1;
                end
                last_index_o <= smp_index_i;
                acc_count_o  <= acc_count_o + 16'h0001;
            end
        end
    end
endmodule : card_logger_model

// >>> log_readout_and_card_status_test.sv
`timescale 1ns/1ps
module log_readout_and_card_status_test
    import log_pkg::*;
;
    logic clk_i = 1'b0, nrst_i = 1'b0, req_valid_i = 1'b0, req_write_i = 1'b0;
    access_mode_t req_mode_i = MODE_ASCII;
    logic [15:0] req_addr_i = 16'h0000, req_wdata_i = 16'h0000;
    logic [7:0]  status_i = 8'h00;
    logic [3:0]  log_burst_i = 4'h0;
    logic        log_go_i = 1'b0, slow_i = 1'b0, clr_i = 1'b0;
    logic        busy_o, rsp_valid_o, rsp_err_o, rsp_nodata_o, rsp_done_o;
    logic        smp_valid_o, smp_ready, log_sample, seq_err;
    logic [15:0] rsp_data_o, smp_index_o, acc_count, first_index, last_index;
    logic [7:0]  mod_type, card_status, fw_ver, capacity;
    int          bad_count = 0, n_compared = 0;

    log_readout u_log_readout (.clk_i(clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
        .req_write_i(req_write_i), .req_mode_i(req_mode_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .busy_o(busy_o), .rsp_valid_o(rsp_valid_o),
        .rsp_data_o(rsp_data_o), .rsp_err_o(rsp_err_o), .rsp_nodata_o(rsp_nodata_o),
        .rsp_done_o(rsp_done_o), .smp_valid_o(smp_valid_o), .smp_index_o(smp_index_o),
        .smp_ready_i(smp_ready), .log_sample_i(log_sample), .card_module_type_i(mod_type),
        .card_status_i(card_status), .card_fw_version_i(fw_ver), .card_capacity_i(capacity));

    card_logger_model u_card_logger_model (.clk_i(clk_i), .nrst_i(nrst_i),
        .status_i(status_i), .log_burst_i(log_burst_i), .log_go_i(log_go_i), .slow_i(slow_i),
        .clr_i(clr_i), .smp_valid_i(smp_valid_o), .smp_index_i(smp_index_o),
        .smp_ready_o(smp_ready), .log_sample_o(log_sample), .module_type_o(mod_type),
        .status_o(card_status), .fw_version_o(fw_ver), .capacity_o(capacity),
        .acc_count_o(acc_count), .first_index_o(first_index), .last_index_o(last_index),
        .seq_err_o(seq_err));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
            bad_count++;
        end
    endtask : check

    // One register access; flags are {err, nodata, done}
    task automatic xfer(input logic wr, input access_mode_t md, input logic [15:0] addr,
                        input logic [15:0] wdata, input logic [15:0] exp_data,
                        input logic [2:0] exp_flags);
        int i;
        @(negedge clk_i);
        req_valid_i = 1'b1;
        req_write_i = wr;
        req_mode_i  = md;
        req_addr_i  = addr;
        req_wdata_i = wdata;
        @(negedge clk_i);
        req_valid_i = 1'b0;
        for (i = 0; i < 400 && rsp_valid_o !== 1'b1; i++) @(negedge clk_i);
        if (i == 400) begin
            $display("Error at %0t: no answer from %h", $time, addr);
            bad_count++;
            end_of_test();
        end
        check({12'h000, busy_o, rsp_err_o, rsp_nodata_o, rsp_done_o}, {13'h0000, exp_flags},
              "flags");
        if (!wr && !exp_flags[2]) check(rsp_data_o, exp_data, "data");
    endtask : xfer

    task automatic rd(input logic [15:0] addr, input logic [15:0] exp, input logic [2:0] fl);
        xfer(1'b0, MODE_ASCII, addr, 16'h0000, exp, fl);
    endtask : rd

    task automatic wr(input logic [15:0] addr, input logic [15:0] data);
        xfer(1'b1, MODE_ASCII, addr, data, 16'h0000, 3'b000);
    endtask : wr

    task automatic pulse_clr;
        @(negedge clk_i);
        clr_i = 1'b1;
        @(negedge clk_i);
        clr_i = 1'b0;
    endtask : pulse_clr

    initial begin
        repeat (12) @(negedge clk_i);
        nrst_i = 1'b1;
        rd(REG_LOG_WRITE_PTR, PTR_RST, 3'b000);
        rd(REG_LOG_READ_PTR, PTR_RST, 3'b000);
        rd(REG_SAMPLE_LIMIT, LIMIT_RST, 3'b000);
        $display("test reset_values done");
        rd(REG_MODULE_TYPE, 16'h005a, 3'b000);
        rd(REG_FIRMWARE_VERSION, 16'h0013, 3'b000);
        rd(REG_CARD_CAPACITY, 16'h0058, 3'b000);
        for (int b = 0; b < 8; b++) begin
            status_i = 8'h01 << b;
            repeat (4) @(negedge clk_i);
            rd(REG_STATUS_FLAGS, {8'h00, 8'h01 << b}, 3'b000);
        end
        status_i = 8'hff;
        repeat (4) @(negedge clk_i);
        rd(REG_STATUS_FLAGS, 16'h00ff, 3'b000);
        $display("test card_registers done");
        for (int m = 1; m < 4; m++) begin
            xfer(1'b0, access_mode_t'(m), REG_MULTI_LOG_READ, 16'h0000, 16'h0000, 3'b100);
        end
        xfer(1'b1, MODE_ASCII, REG_MULTI_LOG_READ, 16'h0001, 16'h0000, 3'b100);
        xfer(1'b1, MODE_ASCII, REG_MODULE_TYPE, 16'h0001, 16'h0000, 3'b100);
        rd(16'h0005, 16'h0000, 3'b100);
        $display("test refusals done");
        rd(REG_SINGLE_LOG_READ, 16'h0000, 3'b010);
        @(negedge clk_i);
        log_burst_i = 4'h3;
        log_go_i = 1'b1;
        @(negedge clk_i);
        log_go_i = 1'b0;
        repeat (6) @(negedge clk_i);
        rd(REG_LOG_WRITE_PTR, 16'h0003, 3'b000);
        rd(REG_SINGLE_LOG_READ, 16'h0001, 3'b000);
        pulse_clr();
        slow_i = 1'b1;
        rd(REG_MULTI_LOG_READ, 16'h0002, 3'b001);
        rd(REG_LOG_READ_PTR, 16'h0003, 3'b000);
        check(acc_count, 16'h0002, "accepted");
        check(first_index, 16'h0001, "first");
        check({15'h0000, seq_err}, 16'h0000, "order");
        $display("test slow_stream done");
        rd(REG_MULTI_LOG_READ, 16'h0000, 3'b001);
        rd(REG_LOG_READ_PTR, 16'h0003, 3'b000);
        rd(REG_LOG_WRITE_PTR, 16'h0003, 3'b000);
        $display("test empty_stream done");
        slow_i = 1'b0;
        wr(REG_SAMPLE_LIMIT, 16'h0002);
        wr(REG_LOG_WRITE_PTR, 16'h000a);
        wr(REG_LOG_READ_PTR, 16'h0004);
        pulse_clr();
        rd(REG_MULTI_LOG_READ, 16'h0002, 3'b001);
        rd(REG_LOG_READ_PTR, 16'h0006, 3'b000);
        check(last_index, 16'h0005, "last");
        wr(REG_SAMPLE_LIMIT, LIMIT_RST);
        rd(REG_MULTI_LOG_READ, 16'h0004, 3'b001);
        rd(REG_LOG_READ_PTR, 16'h000a, 3'b000);
        $display("test range_and_limit done");
        wr(REG_LOG_WRITE_PTR, 16'h0000);
        wr(REG_LOG_READ_PTR, 16'h0000);
        rd(REG_SINGLE_LOG_READ, 16'h0000, 3'b010);
        $display("test clear done");
        end_of_test();
    end
endmodule : log_readout_and_card_status_test
